// [verilog/ccr_pkg.sv]
`default_nettype none
package ccr_pkg;
    localparam logic [7:0] CCR_ADDR_TWO = 8'h06;
    localparam logic [7:0] CCR_ADDR_THREE = 8'h07;
    localparam logic [7:0] CCR_ADDR_FOUR = 8'h08;
    localparam logic [7:0] CCR_RST_TWO = 8'h7D;
    localparam logic [7:0] CCR_RST_THREE = 8'h0A;
    localparam logic [7:0] CCR_RST_FOUR = 8'h0D;
    // bits that survive a watchdog expiry
    localparam logic [7:0] CCR_WD_KEEP_TWO = 8'h03;
    localparam logic [7:0] CCR_WD_KEEP_THREE = 8'h8F;
    localparam logic [7:0] CCR_WD_KEEP_FOUR = 8'h00;
    localparam int CCR_BIT_BUCK = 7;
    localparam int CCR_BIT_AUTODET = 6;
    localparam int CCR_BIT_CHG = 3;
    localparam int CCR_BIT_PRECHG = 2;
    localparam int CCR_BIT_LIGHT_OFF = 7;
    localparam int CCR_BIT_KICK = 6;
    localparam logic [1:0] CCR_WD_SEL_RST = 2'h1;
    localparam int CCR_CLK_HZ = 250_000_000;
    localparam longint CCR_WD_BASE_S = 40;
    localparam longint CCR_WD_BASE_CYC = CCR_WD_BASE_S * CCR_CLK_HZ;
    localparam logic [15:0] CCR_MV_RECHG_BASE = 16'h0064;
    localparam logic [15:0] CCR_MV_STEP = 16'h0064;
    localparam logic [15:0] CCR_MV_FLOOR_BASE = 16'h1770;
    localparam logic [15:0] CCR_MV_VSET_LO = 16'h1F40;
    localparam logic [15:0] CCR_MV_VSET_HI = 16'h206C;
    localparam logic [7:0] CCR_THERM_BASE = 8'h3C;
    localparam logic [7:0] CCR_THERM_STEP = 8'h14;
    typedef enum logic [1:0] {
        CCR_WD_IDLE = 2'b00,
        CCR_WD_RUN = 2'b01,
        CCR_WD_EXPIRED = 2'b10
    } ccr_wd_state_type;
endpackage : ccr_pkg
`default_nettype wire

// [verilog/ccr_wd_timer.sv]
`default_nettype none
module ccr_wd_timer #(
    parameter longint BASE_CYC = ccr_pkg::CCR_WD_BASE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [1:0] period_sel,
    input wire logic kick,
    output logic expire
);
    import ccr_pkg::*;
    // **********************
    // period counter
    // **********************
    ccr_wd_state_type state_r, state_nxt;
    logic [39:0] cnt_r, cnt_nxt;
    logic expire_nxt;
    logic [39:0] limit;
    always_comb begin
        case (period_sel)
            2'h1: limit = 40'(BASE_CYC);
            2'h2: limit = 40'(BASE_CYC * 2);
            default: limit = 40'(BASE_CYC * 4);
        endcase
    end
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        expire_nxt = 1'b0;
        case (state_r)
            CCR_WD_IDLE: begin
                cnt_nxt = '0;
                if (period_sel != 2'h0) state_nxt = CCR_WD_RUN;
            end
            CCR_WD_RUN: begin
                if (period_sel == 2'h0) begin
                    state_nxt = CCR_WD_IDLE;
                end else if (kick) begin
                    cnt_nxt = '0;
                end else if (cnt_r + 40'h1 >= limit) begin
                    expire_nxt = 1'b1;
                    state_nxt = CCR_WD_EXPIRED;
                end else begin
                    cnt_nxt = cnt_r + 40'h1;
                end
            end
            CCR_WD_EXPIRED: begin
                // re-arms only on a kick or when period_sel drops to 0, so one expiry gives one restore
                cnt_nxt = '0;
                if (kick || period_sel == 2'h0) state_nxt = CCR_WD_IDLE;
            end
            default: state_nxt = CCR_WD_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= CCR_WD_IDLE;
            cnt_r <= '0;
            expire <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            expire <= expire_nxt;
        end
    end
endmodule : ccr_wd_timer
`default_nettype wire

// [verilog/ccr_decode.sv]
`default_nettype none
module ccr_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] two,
    input wire logic [7:0] three,
    input wire logic [7:0] four,
    output logic [7:0] thermal_limit_c,
    output logic [15:0] recharge_offset_mv,
    output logic [15:0] min_system_voltage_mv,
    output logic [5:0] top_off_minutes,
    output logic [15:0] warm_band_voltage_mv,
    output logic warm_band_suspend,
    output logic [6:0] warm_band_current_pct,
    output logic [6:0] cool_band_current_pct,
    output logic cool_band_suspend
);
    import ccr_pkg::*;
    // **********************
    // field to value decode
    // **********************
    logic [7:0] t_nxt;
    logic [15:0] r_nxt, s_nxt, v_nxt;
    logic [5:0] m_nxt;
    logic [6:0] wh_nxt, cc_nxt;
    always_comb begin
        t_nxt = CCR_THERM_BASE + 8'(CCR_THERM_STEP * two[5:4]);
        r_nxt = CCR_MV_RECHG_BASE + 16'(CCR_MV_STEP * two[1:0]);
        s_nxt = CCR_MV_FLOOR_BASE + 16'(CCR_MV_STEP * three[3:0]);
        m_nxt = 6'(8'h0F * three[5:4]);
        case (four[4:3])
            2'h1: v_nxt = CCR_MV_VSET_LO;
            2'h2: v_nxt = CCR_MV_VSET_HI;
            default: v_nxt = 16'h0000; // zero: suspended or unchanged
        endcase
        wh_nxt = four[2] ? 7'h64 : 7'h28;
        case (four[1:0])
            2'h1: cc_nxt = 7'h14;
            2'h2: cc_nxt = 7'h28;
            2'h3: cc_nxt = 7'h64;
            default: cc_nxt = 7'h00;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            thermal_limit_c <= 8'h78;
            recharge_offset_mv <= 16'h00C8;
            min_system_voltage_mv <= 16'h1B58;
            top_off_minutes <= 6'h00;
            warm_band_voltage_mv <= CCR_MV_VSET_LO;
            warm_band_suspend <= 1'b0;
            warm_band_current_pct <= 7'h64;
            cool_band_current_pct <= 7'h14;
            cool_band_suspend <= 1'b0;
        end else if (ce) begin
            thermal_limit_c <= t_nxt;
            recharge_offset_mv <= r_nxt;
            min_system_voltage_mv <= s_nxt;
            top_off_minutes <= m_nxt;
            warm_band_voltage_mv <= v_nxt;
            warm_band_suspend <= (four[4:3] == 2'h0);
            warm_band_current_pct <= wh_nxt;
            cool_band_current_pct <= cc_nxt;
            cool_band_suspend <= (four[1:0] == 2'h0);
        end
    end
endmodule : ccr_decode
`default_nettype wire

// [verilog/ccr_regs.sv]
// Overview of operation
// - bit 7 of control two enables buck output; resets to 0.
// - with buck and charge both set, charging wins, no buck mode.
// - bit 6 enables automatic source detection at plug-in; default 1.
// - bits 5:4 pick thermal limit 60/80/100/120 C; reset 11.
// - bit 3 enables charging; reset value 1.
// - bit 2 picks precharge exit threshold 5.6 V or 6.0 V.
// - bits 1:0 give recharge offset 100 mV plus 100 mV per step.
// - control three bit 7 at 1 disables light-load mode; default 0.
// - writing 1 to kick restarts watchdog; bit then clears itself.
// - bits 5:4 give top-off timer off/15/30/45 minutes.
// - bits 3:0 give minimum system voltage 6.0 V plus 100 mV steps.
// - control four bits 7:6 pick buck hot limit or disable it.
// - bit 5 picks buck cold limit 77 or 80 percent.
// - bits 4:3 give warm band voltage: suspend, 8.0, 8.3, unchanged.
// - bit 2 gives warm band current 40 or 100 percent.
// - bits 1:0 give cool band current: suspend, 20, 40, 100 percent.
// - register reset restores all; watchdog restores all but three fields.
// - control three at address 07h, reset value 0Ah.
// - control four at address 08h, reset value 0Dh.
// - control two at address 06h, reset value 7Dh.
// - watchdog period off, 40, 80 or 160 s; expiry restores fields.
`default_nettype none
module ccr_regs #(
    parameter longint WD_BASE_CYC = ccr_pkg::CCR_WD_BASE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reg_reset,
    input wire logic [1:0] wd_period_sel,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic buck_output_enable,
    output logic buck_active,
    output logic charge_active,
    output logic auto_source_detect_enable,
    output logic [1:0] thermal_limit_select,
    output logic precharge_exit_threshold,
    output logic light_load_mode_disable,
    output logic [1:0] buck_hot_limit,
    output logic buck_hot_protect_off,
    output logic buck_cold_limit,
    output logic watchdog_expired,
    output logic [7:0] thermal_limit_c,
    output logic [15:0] recharge_offset_mv,
    output logic [15:0] min_system_voltage_mv,
    output logic [5:0] top_off_minutes,
    output logic [15:0] warm_band_voltage_mv,
    output logic warm_band_suspend,
    output logic [6:0] warm_band_current_pct,
    output logic [6:0] cool_band_current_pct,
    output logic cool_band_suspend
);
    import ccr_pkg::*;

    // **********************
    // helpers
    // **********************
    function automatic logic [7:0] wd_restore(input logic [7:0] cur, input logic [7:0] rv,
                                              input logic [7:0] keep);
        wd_restore = (cur & keep) | (rv & ~keep);
    endfunction : wd_restore

    // **********************
    // register storage
    // **********************
    logic [7:0] two_r, two_nxt;
    logic [7:0] three_r, three_nxt;
    logic [7:0] four_r, four_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic wd_expire;
    logic kick_pulse;

    // kick only held one cycle: the timer sees it, then the bit drops
    assign kick_pulse = three_r[CCR_BIT_KICK];

    always_comb begin
        two_nxt = two_r;
        three_nxt = three_r;
        four_nxt = four_r;
        three_nxt[CCR_BIT_KICK] = 1'b0;
        if (reg_reset) begin
            two_nxt = CCR_RST_TWO;
            three_nxt = CCR_RST_THREE;
            four_nxt = CCR_RST_FOUR;
        end else begin
            if (wd_expire) begin
                two_nxt = wd_restore(two_r, CCR_RST_TWO, CCR_WD_KEEP_TWO);
                three_nxt = wd_restore(three_nxt, CCR_RST_THREE, CCR_WD_KEEP_THREE);
                four_nxt = wd_restore(four_r, CCR_RST_FOUR, CCR_WD_KEEP_FOUR);
            end
            // a host write after expiry in the same cycle lands on top
            if (wr_en) begin
                case (addr)
                    CCR_ADDR_TWO: two_nxt = wdata;
                    CCR_ADDR_THREE: three_nxt = wdata;
                    CCR_ADDR_FOUR: four_nxt = wdata;
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        rvalid_nxt = rd_en;
        case (addr)
            CCR_ADDR_TWO: rdata_nxt = two_r;
            CCR_ADDR_THREE: rdata_nxt = three_r & ~(8'h01 << CCR_BIT_KICK);
            CCR_ADDR_FOUR: rdata_nxt = four_r;
            default: rdata_nxt = 8'h00;
        endcase
        if (!rd_en) rdata_nxt = 8'h00;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            two_r <= CCR_RST_TWO;
            three_r <= CCR_RST_THREE;
            four_r <= CCR_RST_FOUR;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else if (ce) begin
            two_r <= two_nxt;
            three_r <= three_nxt;
            four_r <= four_nxt;
            rdata <= rdata_nxt;
            rvalid <= rvalid_nxt;
        end
    end

    // **********************
    // watchdog
    // **********************
    ccr_wd_timer #(
        .BASE_CYC(WD_BASE_CYC)
    ) ccr_wd_timer_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .period_sel(wd_period_sel),
        .kick(kick_pulse),
        .expire(wd_expire)
    );

    // **********************
    // control outputs
    // **********************
    logic buck_nxt, chg_nxt, wdx_r, wdx_nxt;
    always_comb begin
        chg_nxt = two_r[CCR_BIT_CHG];
        buck_nxt = two_r[CCR_BIT_BUCK] & ~two_r[CCR_BIT_CHG];
        // expiry flag sticks until a kick; a new expiry in that cycle wins
        wdx_nxt = wd_expire | (wdx_r & ~kick_pulse);
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            buck_output_enable <= 1'b0;
            buck_active <= 1'b0;
            charge_active <= 1'b1;
            auto_source_detect_enable <= 1'b1;
            thermal_limit_select <= 2'h3;
            precharge_exit_threshold <= 1'b1;
            light_load_mode_disable <= 1'b0;
            buck_hot_limit <= 2'h0;
            buck_hot_protect_off <= 1'b0;
            buck_cold_limit <= 1'b0;
            wdx_r <= 1'b0;
        end else if (ce) begin
            buck_output_enable <= two_r[CCR_BIT_BUCK];
            buck_active <= buck_nxt;
            charge_active <= chg_nxt;
            auto_source_detect_enable <= two_r[CCR_BIT_AUTODET];
            thermal_limit_select <= two_r[5:4];
            precharge_exit_threshold <= two_r[CCR_BIT_PRECHG];
            light_load_mode_disable <= three_r[CCR_BIT_LIGHT_OFF];
            buck_hot_limit <= four_r[7:6];
            buck_hot_protect_off <= (four_r[7:6] == 2'h3);
            buck_cold_limit <= four_r[5];
            wdx_r <= wdx_nxt;
        end
    end
    assign watchdog_expired = wdx_r;

    // **********************
    // value decode
    // **********************
    ccr_decode ccr_decode_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .two(two_r),
        .three(three_r),
        .four(four_r),
        .thermal_limit_c(thermal_limit_c),
        .recharge_offset_mv(recharge_offset_mv),
        .min_system_voltage_mv(min_system_voltage_mv),
        .top_off_minutes(top_off_minutes),
        .warm_band_voltage_mv(warm_band_voltage_mv),
        .warm_band_suspend(warm_band_suspend),
        .warm_band_current_pct(warm_band_current_pct),
        .cool_band_current_pct(cool_band_current_pct),
        .cool_band_suspend(cool_band_suspend)
    );
endmodule : ccr_regs
`default_nettype wire

// [tb/ccr_host.sv]
`default_nettype none
module ccr_host (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // ************************
    // one request per cycle
    // ************************
    // launched on the falling edge, sampled at the next rising edge
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wdata <= d;
    endtask : xfer
    // released lines flip so stale data never looks live
    task automatic idle();
        xfer(1'b0, 1'b0, ~addr, ~wdata);
    endtask : idle
endmodule : ccr_host
`default_nettype wire

// [tb/ccr_regs_assertions.sv]
`default_nettype none
module ccr_regs_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reg_reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic buck_output_enable,
    input wire logic buck_active,
    input wire logic charge_active,
    input wire logic [1:0] thermal_limit_select,
    input wire logic [1:0] buck_hot_limit,
    input wire logic buck_hot_protect_off,
    input wire logic watchdog_expired,
    input wire logic [7:0] thermal_limit_c
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ************************
    // checks
    // ************************
    a_read_answer: assert property (ce && rd_en |=> rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (ce && !rd_en |=> !rvalid)
        else $error("stray read valid");
    a_unmapped_zero: assert property (
        ce && rd_en && !(addr inside {8'h06, 8'h07, 8'h08}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_kick_reads_zero: assert property (ce && rd_en && addr == 8'h07 |=> !rdata[6])
        else $error("kick bit read back");
    a_charge_priority: assert property (
        buck_active == (buck_output_enable && !charge_active))
        else $error("buck mode against charge priority");
    a_hot_off: assert property (buck_hot_protect_off == (buck_hot_limit == 2'h3))
        else $error("hot protect off wrong");
    a_thermal_scale: assert property (
        thermal_limit_c == 8'h3C + 8'h14 * {6'h00, thermal_limit_select})
        else $error("thermal limit decode wrong");
    a_buck_write: assert property (
        ce && wr_en && addr == 8'h06 && !reg_reset
        |-> ##2 buck_output_enable == $past(wdata[7], 2))
        else $error("buck enable not written");
    a_charge_write: assert property (
        ce && wr_en && addr == 8'h06 && !reg_reset
        |-> ##2 charge_active == $past(wdata[3], 2))
        else $error("charge enable not written");
    a_reg_restore: assert property (
        ce && reg_reset
        |-> ##2 (charge_active && !buck_output_enable && thermal_limit_select == 2'h3))
        else $error("register reset defaults wrong");
    a_kick_clears: assert property (
        ce && wr_en && addr == 8'h07 && wdata[6] && !reg_reset
        |-> ##[1:4] !watchdog_expired)
        else $error("kick left watchdog flag");
    a_wd_restore: assert property (
        $rose(watchdog_expired)
        |-> ##[0:2] (charge_active && thermal_limit_select == 2'h3 && !buck_output_enable))
        else $error("expiry did not restore fields");
    c_read: cover property (rvalid && rdata != 8'h00);
    c_expire: cover property ($rose(watchdog_expired));
    c_buck: cover property (buck_active);
endmodule : ccr_regs_checker
bind ccr_regs ccr_regs_checker ccr_regs_checker_inst (.clk(clk), .rst(rst), .ce(ce),
    .reg_reset(reg_reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid), .buck_output_enable(buck_output_enable),
    .buck_active(buck_active), .charge_active(charge_active),
    .thermal_limit_select(thermal_limit_select), .buck_hot_limit(buck_hot_limit),
    .buck_hot_protect_off(buck_hot_protect_off), .watchdog_expired(watchdog_expired),
    .thermal_limit_c(thermal_limit_c));
`default_nettype wire

// [tb/ccr_regs_tb.sv]
`default_nettype none
module ccr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    // short watchdog base keeps the run small
    localparam longint WD_CYC = 50;
    logic clk, rst, ce, reg_reset, wr_en, rd_en, rvalid;
    logic [1:0] wd_period_sel, thermal_limit_select, buck_hot_limit;
    logic [7:0] addr, wdata, rdata, thermal_limit_c, two, three, four, v;
    logic buck_output_enable, buck_active, charge_active, auto_source_detect_enable;
    logic precharge_exit_threshold, light_load_mode_disable, buck_hot_protect_off;
    logic buck_cold_limit, watchdog_expired, warm_band_suspend, cool_band_suspend;
    logic [15:0] recharge_offset_mv, min_system_voltage_mv, warm_band_voltage_mv;
    logic [5:0] top_off_minutes;
    logic [6:0] warm_band_current_pct, cool_band_current_pct;
    logic [7:0] notes[$];
    int fails, compares, seed, cycles, n, cnt;
    ccr_regs #(.WD_BASE_CYC(WD_CYC)) ccr_regs_inst (.clk(clk), .rst(rst), .ce(ce),
        .reg_reset(reg_reset), .wd_period_sel(wd_period_sel), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
        .buck_output_enable(buck_output_enable), .buck_active(buck_active),
        .charge_active(charge_active), .auto_source_detect_enable(auto_source_detect_enable),
        .thermal_limit_select(thermal_limit_select),
        .precharge_exit_threshold(precharge_exit_threshold),
        .light_load_mode_disable(light_load_mode_disable), .buck_hot_limit(buck_hot_limit),
        .buck_hot_protect_off(buck_hot_protect_off), .buck_cold_limit(buck_cold_limit),
        .watchdog_expired(watchdog_expired), .thermal_limit_c(thermal_limit_c),
        .recharge_offset_mv(recharge_offset_mv), .min_system_voltage_mv(min_system_voltage_mv),
        .top_off_minutes(top_off_minutes), .warm_band_voltage_mv(warm_band_voltage_mv),
        .warm_band_suspend(warm_band_suspend), .warm_band_current_pct(warm_band_current_pct),
        .cool_band_current_pct(cool_band_current_pct), .cool_band_suspend(cool_band_suspend));
    ccr_host ccr_host_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ************************
    // helpers
    // ************************
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ccr_host_inst.xfer(1'b1, 1'b0, a, d);
        if (a == CCR_ADDR_TWO) two = d;
        if (a == CCR_ADDR_THREE) three = d & 8'hBF;
        if (a == CCR_ADDR_FOUR) four = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ccr_host_inst.xfer(1'b0, 1'b1, a, 8'h00);
        notes.push_back(a == CCR_ADDR_TWO ? two : a == CCR_ADDR_THREE ? three :
            a == CCR_ADDR_FOUR ? four : 8'h00);
    endtask : rd
    // decodes lag the register by one cycle, so wait two edges first
    task automatic check_all();
        ccr_host_inst.idle();
        @(negedge clk);
        check("buck", buck_output_enable, two[7]);
        check("buck act", buck_active, two[7] & ~two[3]);
        check("autodet", auto_source_detect_enable, two[6]);
        check("therm", thermal_limit_c, 16'd60 + 16'd20 * two[5:4]);
        check("chg", charge_active, two[3]);
        check("prechg", precharge_exit_threshold, two[2]);
        check("rechg", recharge_offset_mv, 16'd100 + 16'd100 * two[1:0]);
        check("pfm", light_load_mode_disable, three[7]);
        check("topoff", top_off_minutes, 16'd15 * three[5:4]);
        check("floor v", min_system_voltage_mv, 16'd6000 + 16'd100 * three[3:0]);
        check("hot", buck_hot_limit, four[7:6]);
        check("hot off", buck_hot_protect_off, four[7:6] == 2'h3);
        check("cold", buck_cold_limit, four[5]);
        check("warm v", warm_band_voltage_mv, four[4:3] == 2'h1 ? 16'd8000 :
            four[4:3] == 2'h2 ? 16'd8300 : 16'd0);
        check("warm susp", warm_band_suspend, four[4:3] == 2'h0);
        check("warm i", warm_band_current_pct, four[2] ? 16'd100 : 16'd40);
        check("cool i", cool_band_current_pct, four[1:0] == 2'h0 ? 16'd0 :
            four[1:0] == 2'h1 ? 16'd20 : four[1:0] == 2'h2 ? 16'd40 : 16'd100);
        check("cool susp", cool_band_suspend, four[1:0] == 2'h0);
    endtask : check_all
    // ************************
    // read monitor and hang guard
    // ************************
    always @(negedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            results();
        end
        if (rvalid === 1'b1) begin
            if (notes.size() == 0) check("rvalid", 16'h1, 16'h0);
            else check("rdata", rdata, notes.pop_front());
        end
    end
    // ************************
    // main sequence
    // ************************
    initial begin
        seed = 32'h5f97;
        fails = 0;
        compares = 0;
        cycles = 0;
        rst = 1'b1;
        ce = 1'b1;
        reg_reset = 1'b0;
        wd_period_sel = 2'h0;
        two = CCR_RST_TWO;
        three = CCR_RST_THREE;
        four = CCR_RST_FOUR;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check_all();
        for (n = 5; n < 10; n++) rd(8'(n));
        // unmapped 05h and 09h included, reads follow writes back to back
        for (n = 0; n < 40; n++) begin
            v = 8'($random(seed));
            wr(8'h05 + 8'({$random(seed)} % 5), v);
            rd(CCR_ADDR_TWO);
            rd(CCR_ADDR_THREE);
            rd(CCR_ADDR_FOUR);
            check_all();
        end
        // write in the reset cycle must lose
        ccr_host_inst.xfer(1'b1, 1'b0, CCR_ADDR_TWO, 8'h80);
        reg_reset <= 1'b1;
        ccr_host_inst.idle();
        reg_reset <= 1'b0;
        two = CCR_RST_TWO;
        three = CCR_RST_THREE;
        four = CCR_RST_FOUR;
        check_all();
        // ce low freezes everything, so this write must not land
        ce = 1'b0;
        ccr_host_inst.xfer(1'b1, 1'b0, CCR_ADDR_TWO, ~two);
        ccr_host_inst.idle();
        ce = 1'b1;
        check_all();
        wr(CCR_ADDR_TWO, 8'h86);
        wr(CCR_ADDR_THREE, 8'hB5);
        wr(CCR_ADDR_FOUR, 8'hFE);
        check_all();
        for (n = 1; n < 4; n++) begin
            wd_period_sel = 2'(n);
            wr(CCR_ADDR_THREE, three | 8'h40);
            ccr_host_inst.idle();
            repeat (2) @(negedge clk);
            check("wd flag", watchdog_expired, 16'h0);
            cnt = 3;
            while (watchdog_expired !== 1'b1 && cnt < 1000) begin
                @(negedge clk);
                cnt++;
            end
            check("wd period", cnt >= WD_CYC * (1 << (n - 1)) &&
                cnt <= WD_CYC * (1 << (n - 1)) + 8, 16'h1);
            two = (two & CCR_WD_KEEP_TWO) | (CCR_RST_TWO & ~CCR_WD_KEEP_TWO);
            three = (three & CCR_WD_KEEP_THREE) | (CCR_RST_THREE & ~CCR_WD_KEEP_THREE);
            four = (four & CCR_WD_KEEP_FOUR) | (CCR_RST_FOUR & ~CCR_WD_KEEP_FOUR);
            rd(CCR_ADDR_TWO);
            rd(CCR_ADDR_THREE);
            rd(CCR_ADDR_FOUR);
            check_all();
        end
        wd_period_sel = 2'h0;
        repeat (3) @(negedge clk);
        // mid-run reset clears the sticky expiry flag and all three registers
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        two = CCR_RST_TWO;
        three = CCR_RST_THREE;
        four = CCR_RST_FOUR;
        check_all();
        check("wd flag", watchdog_expired, 16'h0);
        check("notes left", 16'(notes.size()), 16'h0);
        results();
    end
endmodule : ccr_regs_tb
`default_nettype wire
